/* File: rtl/touch_cfg.svh */
// Offsets, field positions, reset values and edge counts of the touch power control
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH
`define CMD_START_BIT    7
`define CMD_MODE_BIT     3
`define CMD_SER_BIT      2
`define CMD_PD1_BIT      1
`define CMD_PD0_BIT      0
`define RESET_CMD        8'h00
`define SLEEP_CHANNEL    3'h6
`define CHAN_Y_AXIS      3'h1
`define CHAN_Z1          3'h3
`define CHAN_Z2          3'h4
`define CHAN_X_AXIS      3'h5
`define SW_Y_AXIS        4'h3
`define SW_PRESSURE      4'h6
`define SW_X_AXIS        4'hC
`define SW_PEN_WAIT      4'h1
`define SW_OPEN          4'h0
`define EDGE_CHAN        5'h04
`define EDGE_SW          5'h05
`define EDGE_SER         5'h06
`define EDGE_REF         5'h07
`define EDGE_CMD         5'h08
`define FALL_TRACK_START 5'h05
`define FALL_TRACK_END   5'h08
`define FALL_CONV_END    5'h14
`define CNT_MAX          5'h1F
`endif

/* File: rtl/touch_pkg.sv */
// Types shared by the touch power and sleep control
package touch_pkg;
	typedef logic [2:0] channel_t;
	typedef logic [4:0] edge_count_t;
	typedef enum logic [1:0] {
		awake      = 2'b00,
		sleep_hiz  = 2'b01,
		sleep_high = 2'b10
	} sleep_t;
endpackage : touch_pkg

/* File: rtl/touch_adc_power_sleep_control.sv */
// Power, panel switch, pen interrupt and sleep control of a touch converter
// Summary of operation
// - Accepted command loads stored settings, reference bit one edge before the rest
// - Last accepted command state held until next
// - Sleep is channel 110 with differential select
// - Asleep, select high: panel open, irq per mode
// - Sleep outputs only while chip select high
// - Sleep entered at rising serial edge eight
// - Sleep command power bits also applied
// - Ordinary command returns device to normal operation
// - After power-up device is awake
// - Reference bit takes effect at rising edge seven
// - Converter bit takes effect at rising edge eight
// - Converter on: switches held until rising edge five
// - Converter on, select high, awake: only Y-minus closed
// - Auto power-down: converter on during conversion only
// - Auto mode: pen detect enabled outside conversion
// - Converter-only: powered, axis drivers on while selected
// - Reference-only: reference always on, converter auto
// - Reference-only: pen detect off falls five-twenty
// - Both bits: irq high while select high
// - Eight bits, MSB first, on rising edges
// - Select high, awake, not both bits: touch pulls irq low
`include "touch_cfg.svh"

module touch_adc_power_sleep_control (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         chip_select_n,
	input  wire logic         serial_clock,
	input  wire logic         data_in,
	input  wire logic         touch_detect,
	output logic              ref_power_on,
	output logic              conv_power_on,
	output logic              x_plus_pin,
	output logic              x_minus_pin,
	output logic              y_plus_pin,
	output logic              y_minus_pin,
	output logic              touch_irq_n,
	output logic              touch_irq_oe_n,
	output logic              asleep,
	output touch_pkg::channel_t channel_sel,
	output logic              resolution_sel,
	output logic              single_ended_sel,
	output logic              ref_power_bit,
	output logic              conv_power_bit
);

	// Switch pattern {x+, x-, y+, y-} closed for a channel
	function automatic logic [3:0] sw_pattern(input touch_pkg::channel_t ch);
		case (ch)
			`CHAN_Y_AXIS: sw_pattern = `SW_Y_AXIS;
			`CHAN_Z1:     sw_pattern = `SW_PRESSURE;
			`CHAN_Z2:     sw_pattern = `SW_PRESSURE;
			`CHAN_X_AXIS: sw_pattern = `SW_X_AXIS;
			default:      sw_pattern = `SW_OPEN;
		endcase
	endfunction : sw_pattern

	// Position channels, whose drivers keep the irq pulled low
	function automatic logic is_axis(input touch_pkg::channel_t ch);
		is_axis = (ch == `CHAN_X_AXIS) || (ch == `CHAN_Y_AXIS);
	endfunction : is_axis

	logic [3:0]            sync_a;
	logic [3:0]            sync_b;
	logic [3:0]            sync_c;
	logic [3:0]            filt;
	logic                  sclk_prev;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  cs_low;
	logic                  touched;
	touch_pkg::edge_count_t rise_cnt;
	touch_pkg::edge_count_t fall_cnt;
	logic [7:0]            cmd_shift;
	logic [7:0]            next_cmd;
	logic                  started;
	touch_pkg::channel_t   live_chan;
	logic                  live_ser;
	touch_pkg::sleep_t     sleep_state;
	logic [3:0]            next_sw;
	logic                  next_conv_on;
	logic                  next_irq_n;
	logic                  next_irq_oe_n;
	logic                  in_conv;
	logic                  in_track;

	// Pins cross into this clock through three stages
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sync_a <= 4'h1;
			sync_b <= 4'h1;
			sync_c <= 4'h1;
		end else begin
			sync_a <= {touch_detect, data_in, serial_clock, chip_select_n};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// A change counts only when the second and third stage agree
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			filt <= 4'h1;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (sync_b[i] == sync_c[i]) begin
					filt[i] <= sync_c[i];
				end
			end
		end
	end

	assign cs_low    = ~filt[0];
	assign touched   = filt[3];
	assign sclk_rise = filt[1] & ~sclk_prev;
	assign sclk_fall = ~filt[1] & sclk_prev;
	assign next_cmd  = {cmd_shift[6:0], filt[2]};

	// Serial clock edge detection on the filtered level
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= filt[1];
		end
	end

	// Edge counters run only inside a frame; saturate so long frames are harmless
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rise_cnt <= 5'h00;
			fall_cnt <= 5'h00;
		end else if (!cs_low) begin
			rise_cnt <= 5'h00;
			fall_cnt <= 5'h00;
		end else begin
			if (sclk_rise && rise_cnt != `CNT_MAX) begin
				rise_cnt <= rise_cnt + 5'h01;
			end
			if (sclk_fall && fall_cnt != `CNT_MAX) begin
				fall_cnt <= fall_cnt + 5'h01;
			end
		end
	end

	// Command bits enter MSB first on rising serial edges
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cmd_shift <= 8'h00;
		end else if (!cs_low) begin
			cmd_shift <= 8'h00;
		end else if (sclk_rise && rise_cnt < `EDGE_CMD) begin
			cmd_shift <= next_cmd;
		end
	end

	// Channel and mode of the command in flight, for the tracking window
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			live_chan <= 3'h0;
			live_ser  <= 1'b0;
		end else if (cs_low && sclk_rise) begin
			if (rise_cnt == `EDGE_CHAN - 5'h01) begin
				live_chan <= next_cmd[2:0];
			end
			if (rise_cnt == `EDGE_SER - 5'h01) begin
				live_ser <= next_cmd[0];
			end
		end
	end

	// A frame without the start bit leaves every setting alone; at the seventh
	// rise only six bits are in, so the start bit sits one place lower than at the eighth
	assign started = cmd_shift[`CMD_START_BIT - 2];

	// Reference bit lands one edge before the rest of the command
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ref_power_bit <= 1'b0;
		end else if (cs_low && sclk_rise && rise_cnt == `EDGE_REF - 5'h01 && started) begin
			ref_power_bit <= filt[2];
		end
	end

	// Remaining settings load together and hold until the next command
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			channel_sel      <= 3'h0;
			resolution_sel   <= 1'b0;
			single_ended_sel <= 1'b0;
			conv_power_bit   <= 1'b0;
		end else if (cs_low && sclk_rise && rise_cnt == `EDGE_CMD - 5'h01
			&& cmd_shift[`CMD_START_BIT - 1]) begin
			channel_sel      <= next_cmd[6:4];
			resolution_sel   <= next_cmd[`CMD_MODE_BIT];
			single_ended_sel <= next_cmd[`CMD_SER_BIT];
			conv_power_bit   <= next_cmd[`CMD_PD0_BIT];
		end
	end

	// Sleep decision at the eighth rising edge; reset leaves the device awake
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sleep_state <= touch_pkg::awake;
		end else if (cs_low && sclk_rise && rise_cnt == `EDGE_CMD - 5'h01
			&& cmd_shift[`CMD_START_BIT - 1]) begin
			if (next_cmd[6:4] == `SLEEP_CHANNEL && !next_cmd[`CMD_SER_BIT]) begin
				if (next_cmd[`CMD_MODE_BIT]) begin
					sleep_state <= touch_pkg::sleep_hiz;
				end else begin
					sleep_state <= touch_pkg::sleep_high;
				end
			end else begin
				sleep_state <= touch_pkg::awake;
			end
		end
	end

	// Tracking runs from fall five to fall eight, or to twenty when differential
	assign in_conv  = cs_low && fall_cnt >= `FALL_TRACK_START && fall_cnt < `FALL_CONV_END;
	assign in_track = cs_low && fall_cnt >= `FALL_TRACK_START
		&& fall_cnt < (live_ser ? `FALL_TRACK_END : `FALL_CONV_END);

	// Panel driver switches
	always_comb begin
		next_sw = `SW_PEN_WAIT;
		if (!cs_low) begin
			if (sleep_state != touch_pkg::awake) begin
				next_sw = `SW_OPEN;
			end else begin
				next_sw = `SW_PEN_WAIT;
			end
		end else if (rise_cnt < `EDGE_SW) begin
			if (conv_power_bit) begin
				next_sw = {x_plus_pin, x_minus_pin, y_plus_pin, y_minus_pin};
			end else begin
				next_sw = `SW_PEN_WAIT;
			end
		end else if (conv_power_bit && is_axis(live_chan)) begin
			next_sw = sw_pattern(live_chan);
		end else if (in_track) begin
			next_sw = sw_pattern(live_chan);
		end else if (!conv_power_bit) begin
			next_sw = `SW_PEN_WAIT;
		end else begin
			next_sw = `SW_OPEN;
		end
	end

	// Converter is up for the whole frame, or only while converting
	always_comb begin
		if (conv_power_bit) begin
			next_conv_on = cs_low;
		end else begin
			next_conv_on = in_conv;
		end
	end

	// Pen interrupt level and drive enable; enable is low while driving
	always_comb begin
		next_irq_n    = 1'b1;
		next_irq_oe_n = 1'b0;
		if (!cs_low) begin
			if (sleep_state == touch_pkg::sleep_hiz) begin
				next_irq_oe_n = 1'b1;
			end else if (sleep_state == touch_pkg::sleep_high) begin
				next_irq_n = 1'b1;
			end else if (ref_power_bit && conv_power_bit) begin
				next_irq_n = 1'b1;
			end else begin
				next_irq_n = ~touched;
			end
		end else if (in_conv) begin
			next_irq_n = ~is_axis(live_chan);
		end else if (conv_power_bit) begin
			next_irq_n = ~is_axis(channel_sel);
		end else begin
			next_irq_n = ~touched;
		end
	end

	// All outputs leave from flip-flops
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			x_plus_pin     <= 1'b0;
			x_minus_pin    <= 1'b0;
			y_plus_pin     <= 1'b0;
			y_minus_pin    <= 1'b1;
			conv_power_on  <= 1'b0;
			ref_power_on   <= 1'b0;
			touch_irq_n    <= 1'b1;
			touch_irq_oe_n <= 1'b0;
			asleep         <= 1'b0;
		end else begin
			{x_plus_pin, x_minus_pin, y_plus_pin, y_minus_pin} <= next_sw;
			conv_power_on  <= next_conv_on;
			ref_power_on   <= ref_power_bit;
			touch_irq_n    <= next_irq_n;
			touch_irq_oe_n <= next_irq_oe_n;
			asleep         <= sleep_state != touch_pkg::awake;
		end
	end

endmodule : touch_adc_power_sleep_control

/* File: test/serial_host.sv */
// Host side model that shifts commands into the serial link
module serial_host (
	input  wire logic clock,
	output logic      chip_select_n,
	output logic      serial_clock,
	output logic      data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// Select idles high from time zero, as the host must before a first frame
	initial begin
		chip_select_n = 1'b1;
		serial_clock = 1'b0;
		data_in = 1'b0;
	end
	// Half a serial period of 80 ns, moved just after a system clock edge
	task half;
		repeat (8) @(posedge clock);
		#1;
	endtask : half
	task select(input logic level);
		half();
		chip_select_n = level;
	endtask : select
	// Bits go most significant first; a short count ends the frame early
	task send(input logic [7:0] cmd, input int bits);
		select(1'b0);
		for (int i = 7; i > 7 - bits; i--) begin
			data_in = cmd[i];
			half();
			serial_clock = 1'b1;
			half();
			serial_clock = 1'b0;
		end
		half();
		data_in = ~data_in; // Released line must not keep its last bit
		select(1'b1);
		half();
		half();
	endtask : send
endmodule : serial_host

/* File: test/touch_power_properties.sv */
// Port level checks of the touch power and sleep control
module touch_power_properties (
	input wire logic                clock,
	input wire logic                nrst,
	input wire logic                chip_select_n,
	input wire logic                touch_detect,
	input wire logic                ref_power_on,
	input wire logic                conv_power_on,
	input wire logic                x_plus_pin,
	input wire logic                x_minus_pin,
	input wire logic                y_plus_pin,
	input wire logic                y_minus_pin,
	input wire logic                touch_irq_n,
	input wire logic                touch_irq_oe_n,
	input wire logic                asleep,
	input wire touch_pkg::channel_t channel_sel,
	input wire logic                resolution_sel,
	input wire logic                single_ended_sel,
	input wire logic                ref_power_bit,
	input wire logic                conv_power_bit
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic [3:0] hi_cnt;
	logic [3:0] lo_cnt;
	logic [3:0] pins;
	assign pins = {x_plus_pin, x_minus_pin, y_plus_pin, y_minus_pin};
	// Cycles since select last moved; margin covers the input sync latency
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hi_cnt <= 4'h0;
			lo_cnt <= 4'h0;
		end else begin
			hi_cnt <= !chip_select_n ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
			lo_cnt <= chip_select_n ? 4'h0 : lo_cnt + {3'h0, lo_cnt != 4'hF};
		end
	end
	sequence idle_s;
		hi_cnt > 4'h8;
	endsequence
	sequence quiet_s;
		(hi_cnt > 4'h8 && !asleep && $stable(touch_detect)) [*6];
	endsequence
	sleep_open_a: assert property (idle_s ##0 asleep |-> pins == 4'h0)
		else $error("panel not open while asleep");
	sleep_hiz_a: assert property (idle_s ##0 asleep && resolution_sel |-> touch_irq_oe_n)
		else $error("irq driven in floating sleep");
	sleep_high_a: assert property (idle_s ##0 asleep && !resolution_sel |-> touch_irq_n && !touch_irq_oe_n)
		else $error("irq not high in driven sleep");
	pen_wait_a: assert property (idle_s ##0 !asleep |-> pins == 4'h1)
		else $error("pen wait switches wrong");
	conv_idle_a: assert property (idle_s ##0 !conv_power_bit |-> !conv_power_on)
		else $error("converter on while idle");
	ref_follow_a: assert property (idle_s |-> ref_power_on == ref_power_bit)
		else $error("reference power differs from its bit");
	both_high_a: assert property (idle_s ##0 !asleep && ref_power_bit && conv_power_bit |-> touch_irq_n)
		else $error("irq low with both power bits");
	irq_touch_a: assert property (quiet_s ##0 !(ref_power_bit && conv_power_bit) |-> touch_irq_n == !touch_detect)
		else $error("irq does not follow touch");
	fields_hold_a: assert property (idle_s |=> $stable({channel_sel, resolution_sel, single_ended_sel, ref_power_bit, conv_power_bit}))
		else $error("stored fields moved while idle");
	sleep_code_a: assert property ($rose(asleep) |-> channel_sel == 3'h6 && !single_ended_sel && lo_cnt != 4'h0)
		else $error("sleep entered on wrong command");
	wake_code_a: assert property ($fell(asleep) |-> !(channel_sel == 3'h6 && !single_ended_sel))
		else $error("sleep left on sleep command");
	conv_on_a: assert property ((lo_cnt > 4'h8 && conv_power_bit) [*3] |-> conv_power_on)
		else $error("converter off while selected");
endmodule : touch_power_properties

bind touch_adc_power_sleep_control touch_power_properties u_touch_power_properties (.clock, .nrst,
	.chip_select_n, .touch_detect, .ref_power_on, .conv_power_on, .x_plus_pin, .x_minus_pin,
	.y_plus_pin, .y_minus_pin, .touch_irq_n, .touch_irq_oe_n, .asleep, .channel_sel,
	.resolution_sel, .single_ended_sel, .ref_power_bit, .conv_power_bit);

/* File: test/tb_touch_adc_power_sleep_control.sv */
// Self-checking bench of the touch power and sleep control
module tb_touch_adc_power_sleep_control;
	timeunit 1ns;
	timeprecision 100ps;
	logic                clock = 1'b0;
	logic                nrst = 1'b0;
	logic                touch_detect = 1'b0;
	logic                chip_select_n, serial_clock, data_in;
	logic                ref_power_on, conv_power_on, touch_irq_n, touch_irq_oe_n, asleep;
	logic                x_plus_pin, x_minus_pin, y_plus_pin, y_minus_pin;
	logic                resolution_sel, single_ended_sel, ref_power_bit, conv_power_bit;
	touch_pkg::channel_t channel_sel;
	int                  errors = 0;
	int                  comparisons = 0;
	always #5 clock = ~clock;
	serial_host u_serial_host (.clock(clock), .chip_select_n(chip_select_n),
		.serial_clock(serial_clock), .data_in(data_in));
	touch_adc_power_sleep_control u_touch_adc_power_sleep_control (.clock(clock), .nrst(nrst),
		.chip_select_n(chip_select_n), .serial_clock(serial_clock), .data_in(data_in),
		.touch_detect(touch_detect), .ref_power_on(ref_power_on), .conv_power_on(conv_power_on),
		.x_plus_pin(x_plus_pin), .x_minus_pin(x_minus_pin), .y_plus_pin(y_plus_pin),
		.y_minus_pin(y_minus_pin), .touch_irq_n(touch_irq_n), .touch_irq_oe_n(touch_irq_oe_n),
		.asleep(asleep), .channel_sel(channel_sel), .resolution_sel(resolution_sel),
		.single_ended_sel(single_ended_sel), .ref_power_bit(ref_power_bit),
		.conv_power_bit(conv_power_bit));
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task test_done;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	// Stored fields packed as the low seven command bits, for direct comparison
	function logic [7:0] fields;
		return {1'b0, channel_sel, resolution_sel, single_ended_sel, ref_power_bit, conv_power_bit};
	endfunction : fields
	function logic [7:0] pins;
		return {4'h0, x_plus_pin, x_minus_pin, y_plus_pin, y_minus_pin};
	endfunction : pins
	task settle;
		repeat (16) @(posedge clock);
		#1;
	endtask : settle
	task t_power_up;
		check("asleep", asleep, 8'h00);
		check("pins", pins(), 8'h01);
		touch_detect = 1'b1;
		settle();
		check("irq touched", touch_irq_n, 8'h00);
		touch_detect = 1'b0;
		settle();
		check("irq free", touch_irq_n, 8'h01);
	endtask : t_power_up
	task t_fields;
		u_serial_host.send(8'h00, 8);
		u_serial_host.send(8'hDA, 8);
		check("fields", fields(), 8'h5A);
		check("ref on", ref_power_on, 8'h01);
		check("conv on", conv_power_on, 8'h00);
	endtask : t_fields
	// Frame cut after seven rises: only the reference bit may land
	task t_partial;
		u_serial_host.send(8'h80, 8);
		check("cleared fields", fields(), 8'h00);
		u_serial_host.send(8'hAB, 7);
		check("partial fields", fields(), 8'h02);
		u_serial_host.send(8'h55, 8);
		check("no start fields", fields(), 8'h02);
	endtask : t_partial
	task t_sleep;
		for (int m = 1; m >= 0; m--) begin
			u_serial_host.send(m ? 8'hEB : 8'hE3, 8);
			touch_detect = 1'b1;
			settle();
			check("asleep", asleep, 8'h01);
			check("sleep pins", pins(), 8'h00);
			check("oe", touch_irq_oe_n, m[7:0]);
			if (m == 0) check("irq high", touch_irq_n, 8'h01);
			check("sleep power", {ref_power_on, conv_power_bit}, 8'h03);
			u_serial_host.select(1'b0);
			u_serial_host.half();
			check("selected oe", touch_irq_oe_n, 8'h00);
			check("selected conv", conv_power_on, 8'h01);
			u_serial_host.select(1'b1);
			touch_detect = 1'b0;
			u_serial_host.send(8'h91, 8);
			check("awake", asleep, 8'h00);
			check("wait pins", pins(), 8'h01);
		end
	endtask : t_sleep
	task t_both;
		u_serial_host.send(8'h93, 8);
		touch_detect = 1'b1;
		settle();
		check("both irq", touch_irq_n, 8'h01);
		touch_detect = 1'b0;
	endtask : t_both
	// Single-ended X frame in auto mode: drivers close only from fall five to eight
	task t_track;
		u_serial_host.send(8'hD4, 8);
		fork
			u_serial_host.send(8'hD4, 8);
			begin
				repeat (120) @(posedge clock);
				#1;
				check("track pins", pins(), 8'h0C);
				check("track conv", conv_power_on, 8'h01);
				check("track irq", touch_irq_n, 8'h00);
			end
		join
		check("track fields", fields(), 8'h54);
		check("idle conv", conv_power_on, 8'h00);
		check("idle pins", pins(), 8'h01);
	endtask : t_track
	// Runs span a few thousand cycles; the limit leaves ample room
	initial begin
		#100000;
		errors++;
		test_done();
	end
	initial begin
		repeat (10) @(posedge clock);
		#1;
		nrst = 1'b1;
		settle();
		t_power_up();
		t_fields();
		t_partial();
		t_sleep();
		t_both();
		t_track();
		test_done();
	end
endmodule : tb_touch_adc_power_sleep_control
